//--- src/bce_engine.sv
// Blit engine command decode, status reporting, transfer FIFO and sequencer.
//
// Operation
// R1: half flag set when FIFO at least half.
// R2: full flag set only when no entry free.
// R3: busy flag reads one while transfer runs.
// R4: read transfer pauses full, resumes below fourteen.
// R5: command bits 19:16 select combining function.
// R6: colour expansion starts at raster code bits 2:0.
// R7: result bit is code bit at source,destination.
// R8: pattern fill uses pattern in source place.
// R9: operation bits 3:0; code 0 writes from system.
// R10: code 1 reads display memory into FIFO.
// R11: codes 2,3 move up or down with ROP.
// R12: software starts with one, never zero while busy.
// R13: busy rises next cycle, falls after last write.
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/1ps
module bce_engine #(
    parameter int PIX_W        = 16,
    parameter int MEM_AW       = 18,
    parameter int DEPTH        = 16,
    parameter int RESUME_LEVEL = 14
) (
    input  wire logic              i_mclk,
    input  wire logic              i_rst_b,
    input  wire logic [15:0]       i_addr,
    input  wire logic [31:0]       i_wdata,
    input  wire logic              i_wr,
    input  wire logic              i_rd,
    output logic      [31:0]       o_rdata,
    output logic                   o_irq,
    output logic      [MEM_AW-1:0] o_mem_addr,
    output logic                   o_mem_rd,
    output logic                   o_mem_wr,
    output logic      [PIX_W-1:0]  o_mem_wdata,
    input  wire logic [PIX_W-1:0]  i_mem_rdata
);
    localparam int PTR_W = $clog2(DEPTH);
    localparam int CNT_W = PTR_W + 1;

    bce_pkg::bce_state_e        state;
    logic [31:0]                command;
    logic [MEM_AW-1:0]          src_ptr;
    logic [MEM_AW-1:0]          dst_ptr;
    logic [15:0]                remain;
    logic [PIX_W-1:0]           pattern;
    logic [PIX_W-1:0]           src_word;
    logic [PIX_W-1:0]           dst_word;
    logic                       busy;
    logic                       paused;
    logic                       lat;
    logic                       need_word;
    logic [2:0]                 bit_ptr;
    logic [bce_pkg::INT_W-1:0]  int_stat;
    logic [bce_pkg::INT_W-1:0]  int_mask;
    logic [PIX_W-1:0]           fifo_mem [DEPTH];
    logic [PTR_W-1:0]           wr_idx;
    logic [PTR_W-1:0]           rd_idx;
    logic [CNT_W-1:0]           fifo_cnt;
    logic [3:0]                 op;
    logic [3:0]                 rop_code;
    logic                       fifo_full;
    logic                       fifo_half;
    logic                       fifo_nempty;
    logic                       start_req;
    logic                       host_push;
    logic                       host_pop;
    logic                       eng_push;
    logic                       eng_pop;
    logic                       push;
    logic                       pop;
    logic [PIX_W-1:0]           push_data;
    logic                       last;
    logic                       step_down;
    logic                       done_evt;
    logic                       ovf_evt;
    logic [31:0]                status_word;
    logic [PIX_W-1:0]           cexp_pix;

    bce_rop_if #(.PIX_W(PIX_W)) rop_bus ();

    bce_rop_unit #(.PIX_W(PIX_W)) u_rop (
        .i_mclk (i_mclk),
        .i_rst_b(i_rst_b),
        .rop    (rop_bus)
    );

    // Command fields and raster-operation operands.
    assign op            = command[bce_pkg::CMD_OP_LSB +: bce_pkg::CODE_W];   // [R9]
    assign rop_code      = command[bce_pkg::CMD_ROP_LSB +: bce_pkg::CODE_W];  // [R5]
    assign rop_bus.code  = rop_code;                                          // [R5]
    assign rop_bus.src   = src_word;
    assign rop_bus.dst   = dst_word;
    assign cexp_pix      = src_word[bit_ptr] ? pattern : '0;
    assign last          = (remain == 16'h0001);
    assign step_down     = (op == bce_pkg::OP_MOVE_NEG);                      // [R11]

    // FIFO flags from the occupancy count.
    assign fifo_full   = (fifo_cnt == CNT_W'(DEPTH));                         // [R2]
    assign fifo_half   = (fifo_cnt >= CNT_W'(DEPTH / 2));                     // [R1]
    assign fifo_nempty = (fifo_cnt != '0);

    // Host and engine access to the FIFO; the two never compete for one side.
    assign start_req = i_wr && (i_addr == bce_pkg::REG_CTRL)
                       && i_wdata[bce_pkg::CTRL_START_BIT] && !busy;          // [R12]
    assign host_push = i_wr && (i_addr == bce_pkg::REG_DATA) && !fifo_full
                       && !(busy && op == bce_pkg::OP_READ);
    assign ovf_evt   = i_wr && (i_addr == bce_pkg::REG_DATA) && fifo_full;
    assign host_pop  = i_rd && (i_addr == bce_pkg::REG_DATA) && fifo_nempty
                       && !(busy && (op == bce_pkg::OP_WRITE || op == bce_pkg::OP_CEXP));
    assign eng_push  = (state == bce_pkg::BCE_SWAIT) && lat && (op == bce_pkg::OP_READ);
    assign eng_pop   = (state == bce_pkg::BCE_SRC) && fifo_nempty
                       && (op == bce_pkg::OP_WRITE || (op == bce_pkg::OP_CEXP && need_word));
    assign push      = host_push || eng_push;
    assign pop       = host_pop || eng_pop;
    assign push_data = eng_push ? i_mem_rdata : i_wdata[PIX_W-1:0];
    assign done_evt  = (state == bce_pkg::BCE_DONE);

    // FIFO storage and pointers.
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            wr_idx   <= '0;
            rd_idx   <= '0;
            fifo_cnt <= '0;
        end else begin
            if (push) begin
                wr_idx <= wr_idx + PTR_W'(1);
            end
            if (pop) begin
                rd_idx <= rd_idx + PTR_W'(1);
            end
            if (push && !pop) begin
                fifo_cnt <= fifo_cnt + CNT_W'(1);
            end else if (pop && !push) begin
                fifo_cnt <= fifo_cnt - CNT_W'(1);
            end
        end
    end

    // FIFO data words; no reset needed for storage.
    always_ff @(posedge i_mclk) begin
        if (push) begin
            fifo_mem[wr_idx] <= push_data;
        end
    end

    // Software-written configuration registers.
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            command  <= bce_pkg::COMMAND_RESET;
            pattern  <= '0;
            int_mask <= '0;
        end else if (i_wr) begin
            case (i_addr)
                bce_pkg::REG_COMMAND:  command  <= i_wdata;
                bce_pkg::REG_PATTERN:  pattern  <= i_wdata[PIX_W-1:0];
                bce_pkg::REG_INT_MASK: int_mask <= i_wdata[bce_pkg::INT_W-1:0];
                default: ;
            endcase
        end
    end

    // Sticky interrupt status, write one to clear; a new event wins over the clear.
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            int_stat <= '0;
        end else begin
            for (int i = 0; i < bce_pkg::INT_W; i++) begin
                if ((i == bce_pkg::INT_DONE_BIT && done_evt)
                        || (i == bce_pkg::INT_OVF_BIT && ovf_evt)) begin
                    int_stat[i] <= 1'b1;
                end else if (i_wr && i_addr == bce_pkg::REG_INT_STAT && i_wdata[i]) begin
                    int_stat[i] <= 1'b0;
                end
            end
        end
    end

    assign o_irq = |(int_stat & int_mask);

    // Status word layout.
    always_comb begin
        status_word = '0;
        status_word[bce_pkg::ST_BUSY_BIT]   = busy;                          // [R3]
        status_word[bce_pkg::ST_FULL_BIT]   = fifo_full;                     // [R2]
        status_word[bce_pkg::ST_HALF_BIT]   = fifo_half;                     // [R1]
        status_word[bce_pkg::ST_NEMPTY_BIT] = fifo_nempty;
        status_word[bce_pkg::ST_FREE_LSB +: bce_pkg::ST_FIELD_W] =
            bce_pkg::ST_FIELD_W'(CNT_W'(DEPTH) - fifo_cnt);
        status_word[bce_pkg::ST_USED_LSB +: bce_pkg::ST_FIELD_W] =
            bce_pkg::ST_FIELD_W'(fifo_cnt);
    end

    // Read data stands in the cycle after the strobe only; unmapped reads give zero.
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_rdata <= '0;
        end else if (i_rd) begin
            case (i_addr)
                bce_pkg::REG_STATUS:   o_rdata <= status_word;
                bce_pkg::REG_COMMAND:  o_rdata <= command;
                bce_pkg::REG_SRC:      o_rdata <= 32'(src_ptr);
                bce_pkg::REG_DST:      o_rdata <= 32'(dst_ptr);
                bce_pkg::REG_COUNT:    o_rdata <= 32'(remain);
                bce_pkg::REG_PATTERN:  o_rdata <= 32'(pattern);
                bce_pkg::REG_DATA:     o_rdata <= host_pop ? 32'(fifo_mem[rd_idx]) : '0;
                bce_pkg::REG_INT_STAT: o_rdata <= 32'(int_stat);
                bce_pkg::REG_INT_MASK: o_rdata <= 32'(int_mask);
                default:               o_rdata <= '0;
            endcase
        end else begin
            o_rdata <= '0;
        end
    end

    // Read-transfer throttle: stop on full, restart below the resume level.
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            paused <= 1'b0;
        end else if (fifo_full) begin
            paused <= 1'b1;                                                  // [R4]
        end else if (fifo_cnt < CNT_W'(RESUME_LEVEL)) begin
            paused <= 1'b0;                                                  // [R4]
        end
    end

    // Transfer sequencer with address pointers, operands and memory strobes.
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state       <= bce_pkg::BCE_IDLE;
            busy        <= 1'b0;
            src_ptr     <= '0;
            dst_ptr     <= '0;
            remain      <= '0;
            src_word    <= '0;
            dst_word    <= '0;
            lat         <= 1'b0;
            need_word   <= 1'b1;
            bit_ptr     <= '0;
            o_mem_addr  <= '0;
            o_mem_rd    <= 1'b0;
            o_mem_wr    <= 1'b0;
            o_mem_wdata <= '0;
        end else begin
            o_mem_rd <= 1'b0;
            o_mem_wr <= 1'b0;
            if (i_wr && !busy && i_addr == bce_pkg::REG_SRC) begin
                src_ptr <= i_wdata[MEM_AW-1:0];
            end
            if (i_wr && !busy && i_addr == bce_pkg::REG_DST) begin
                dst_ptr <= i_wdata[MEM_AW-1:0];
            end
            if (i_wr && !busy && i_addr == bce_pkg::REG_COUNT) begin
                remain <= i_wdata[15:0];
            end
            unique case (state)
                bce_pkg::BCE_IDLE: begin
                    if (start_req) begin
                        busy      <= 1'b1;                                   // [R13] [R3]
                        need_word <= 1'b1;
                        bit_ptr   <= rop_code[bce_pkg::CEXP_PTR_W-1:0];      // [R6]
                        state     <= (remain == '0) ? bce_pkg::BCE_DONE : bce_pkg::BCE_SRC;
                    end
                end
                bce_pkg::BCE_SRC: begin
                    lat <= 1'b0;
                    unique case (op)
                        bce_pkg::OP_WRITE: begin                             // [R9]
                            if (fifo_nempty) begin
                                src_word <= fifo_mem[rd_idx];
                                state    <= bce_pkg::BCE_DRD;
                            end
                        end
                        bce_pkg::OP_READ: begin                              // [R10]
                            if (!paused && !fifo_full) begin                 // [R4]
                                o_mem_rd   <= 1'b1;
                                o_mem_addr <= src_ptr;
                                state      <= bce_pkg::BCE_SWAIT;
                            end
                        end
                        bce_pkg::OP_MOVE_POS, bce_pkg::OP_MOVE_NEG: begin    // [R11]
                            o_mem_rd   <= 1'b1;
                            o_mem_addr <= src_ptr;
                            state      <= bce_pkg::BCE_SWAIT;
                        end
                        bce_pkg::OP_FILL: begin
                            src_word <= pattern;                             // [R8]
                            state    <= bce_pkg::BCE_DRD;
                        end
                        bce_pkg::OP_CEXP: begin
                            if (!need_word) begin
                                state <= bce_pkg::BCE_WR;
                            end else if (fifo_nempty) begin
                                src_word  <= fifo_mem[rd_idx];
                                need_word <= 1'b0;
                                state     <= bce_pkg::BCE_WR;
                            end
                        end
                        default: state <= bce_pkg::BCE_DONE;
                    endcase
                end
                bce_pkg::BCE_SWAIT: begin
                    lat <= 1'b1;
                    if (lat) begin
                        lat <= 1'b0;
                        if (op == bce_pkg::OP_READ) begin
                            src_ptr <= src_ptr + MEM_AW'(1);                 // [R10]
                            remain  <= remain - 16'h0001;
                            state   <= last ? bce_pkg::BCE_DONE : bce_pkg::BCE_SRC;
                        end else begin
                            src_word <= i_mem_rdata;
                            state    <= bce_pkg::BCE_DRD;
                        end
                    end
                end
                bce_pkg::BCE_DRD: begin
                    o_mem_rd   <= 1'b1;
                    o_mem_addr <= dst_ptr;
                    lat        <= 1'b0;
                    state      <= bce_pkg::BCE_DWAIT;
                end
                bce_pkg::BCE_DWAIT: begin
                    lat <= 1'b1;
                    if (lat) begin
                        dst_word <= i_mem_rdata;
                        state    <= bce_pkg::BCE_WR;
                    end
                end
                bce_pkg::BCE_WR: begin
                    o_mem_wr    <= 1'b1;
                    o_mem_addr  <= dst_ptr;
                    o_mem_wdata <= (op == bce_pkg::OP_CEXP) ? cexp_pix : rop_bus.res; // [R5]
                    dst_ptr     <= step_down ? dst_ptr - MEM_AW'(1) : dst_ptr + MEM_AW'(1);
                    src_ptr     <= step_down ? src_ptr - MEM_AW'(1) : src_ptr + MEM_AW'(1);
                    remain      <= remain - 16'h0001;
                    bit_ptr     <= bit_ptr + 3'h1;                           // [R6]
                    if (bit_ptr == bce_pkg::CEXP_LAST) begin
                        need_word <= 1'b1;
                    end
                    state <= last ? bce_pkg::BCE_DONE : bce_pkg::BCE_SRC;
                end
                bce_pkg::BCE_DONE: begin
                    busy  <= 1'b0;                                           // [R13] [R3]
                    state <= bce_pkg::BCE_IDLE;
                end
                default: state <= bce_pkg::BCE_IDLE;
            endcase
        end
    end

    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_rst_b);

    half_flag_a : assert property (status_word[bce_pkg::ST_HALF_BIT] // [R1]
                                   == (status_word[bce_pkg::ST_FREE_LSB +: bce_pkg::ST_FIELD_W]
                                       <= bce_pkg::ST_FIELD_W'(DEPTH / 2)))
        else $error("half flag disagrees with occupancy");
    full_flag_a : assert property (fifo_full |-> !push || pop) // [R2]
        else $error("push accepted while full");
    busy_rise_a : assert property (start_req |=> busy ##0 $rose(busy)) // [R13]
        else $error("busy did not rise after start");
    busy_fall_a : assert property ($fell(busy) |-> $past(state) == bce_pkg::BCE_DONE) // [R3]
        else $error("busy fell outside completion");
    read_pause_a : assert property (paused && busy && op == bce_pkg::OP_READ
                                    |=> !o_mem_rd) // [R4]
        else $error("read issued while paused");
    resume_a : assert property (paused && !fifo_full && fifo_cnt < CNT_W'(RESUME_LEVEL)
                                |=> !paused) // [R4]
        else $error("read did not resume below level");
    cexp_start_a : assert property (start_req && op == bce_pkg::OP_CEXP
                                    |=> bit_ptr == $past(rop_code[2:0])) // [R6]
        else $error("expansion start bit wrong");
    rop_write_a : assert property (state == bce_pkg::BCE_WR && op != bce_pkg::OP_CEXP
                                   |=> o_mem_wr && o_mem_wdata == $past(rop_bus.res)) // [R5]
        else $error("write data not the combined result");
    fill_src_a : assert property (state == bce_pkg::BCE_WR && op == bce_pkg::OP_FILL
                                  |-> src_word == pattern) // [R8]
        else $error("fill does not use pattern");
    move_neg_a : assert property (state == bce_pkg::BCE_WR && op == bce_pkg::OP_MOVE_NEG
                                  |=> dst_ptr == $past(dst_ptr) - MEM_AW'(1)) // [R11]
        else $error("negative move stepped wrong way");
    read_push_a : assert property (state == bce_pkg::BCE_SWAIT && lat && op == bce_pkg::OP_READ
                                   |=> fifo_nempty) // [R10]
        else $error("read word not queued");
    write_pop_a : assert property (eng_pop && op == bce_pkg::OP_WRITE
                                   |=> state == bce_pkg::BCE_DRD) // [R9]
        else $error("write transfer skipped destination read");

    move_seen_c : cover property (state == bce_pkg::BCE_WR && op == bce_pkg::OP_MOVE_POS);
    read_pause_c : cover property (paused && busy && op == bce_pkg::OP_READ);
    cexp_wrap_c : cover property (op == bce_pkg::OP_CEXP && state == bce_pkg::BCE_WR
                                  && bit_ptr == bce_pkg::CEXP_LAST);
    irq_c : cover property ($rose(o_irq));
endmodule : bce_engine

//--- src/bce_pkg.sv
// Package with register map, field layout and operation codes of the blit command engine.
package bce_pkg;
    // Register byte addresses on the host port.
    localparam logic [15:0] REG_CTRL     = 16'h8000;
    localparam logic [15:0] REG_STATUS   = 16'h8004;
    localparam logic [15:0] REG_COMMAND  = 16'h8008;
    localparam logic [15:0] REG_SRC      = 16'h800c;
    localparam logic [15:0] REG_DST      = 16'h8050;
    localparam logic [15:0] REG_COUNT    = 16'h8054;
    localparam logic [15:0] REG_PATTERN  = 16'h8058;
    localparam logic [15:0] REG_DATA     = 16'h805c;
    localparam logic [15:0] REG_INT_STAT = 16'h8060;
    localparam logic [15:0] REG_INT_MASK = 16'h8064;
    // Field positions.
    localparam int CTRL_START_BIT = 0;
    localparam int CMD_OP_LSB     = 0;
    localparam int CMD_ROP_LSB    = 16;
    localparam int CODE_W         = 4;
    localparam int ST_BUSY_BIT    = 0;
    localparam int ST_FULL_BIT    = 4;
    localparam int ST_HALF_BIT    = 5;
    localparam int ST_NEMPTY_BIT  = 6;
    localparam int ST_FREE_LSB    = 16;
    localparam int ST_USED_LSB    = 24;
    localparam int ST_FIELD_W     = 5;
    localparam int INT_DONE_BIT   = 0;
    localparam int INT_OVF_BIT    = 1;
    localparam int INT_W          = 2;
    localparam int CEXP_PTR_W     = 3;
    // Reset value and last expansion bit.
    localparam logic [31:0] COMMAND_RESET = 32'h0000_0000;
    localparam logic [2:0]  CEXP_LAST     = 3'h7;
    // Operation codes.
    localparam logic [3:0] OP_WRITE    = 4'h0;
    localparam logic [3:0] OP_READ     = 4'h1;
    localparam logic [3:0] OP_MOVE_POS = 4'h2;
    localparam logic [3:0] OP_MOVE_NEG = 4'h3;
    localparam logic [3:0] OP_FILL     = 4'h6;
    localparam logic [3:0] OP_CEXP     = 4'h8;
    // Engine states, Gray coded along the main path.
    typedef enum logic [2:0] {
        BCE_IDLE  = 3'h0,
        BCE_SRC   = 3'h1,
        BCE_SWAIT = 3'h3,
        BCE_DRD   = 3'h2,
        BCE_DWAIT = 3'h6,
        BCE_WR    = 3'h7,
        BCE_DONE  = 3'h5
    } bce_state_e;
endpackage : bce_pkg

//--- src/bce_rop_if.sv
// Interface carrying operands and result between the engine and the raster-operation unit.
`timescale 1ns/1ps
interface bce_rop_if #(parameter int PIX_W = 16);
    logic [3:0]       code;
    logic [PIX_W-1:0] src;
    logic [PIX_W-1:0] dst;
    logic [PIX_W-1:0] res;
    modport engine (output code, output src, output dst, input res);
    modport unit   (input code, input src, input dst, output res);
endinterface : bce_rop_if

//--- src/bce_rop_unit.sv
// Bitwise raster-operation unit: each result bit indexes the four-bit code.
`timescale 1ns/1ps
module bce_rop_unit #(
    parameter int PIX_W = 16
) (
    input wire logic  i_mclk,
    input wire logic  i_rst_b,
    bce_rop_if.unit   rop
);
    // Each bit picks code bit {source, destination}; covers all sixteen functions.
    for (genvar g = 0; g < PIX_W; g++) begin : g_bit
        assign rop.res[g] = rop.code[{rop.src[g], rop.dst[g]}]; // [R7] [R8]
    end

    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_rst_b);

    rop_xor_a : assert property ((rop.code == 4'h6) |-> (rop.res == (rop.src ^ rop.dst))) // [R7]
        else $error("xor code gives wrong result");
    rop_copy_a : assert property ((rop.code == 4'hc) |-> (rop.res == rop.src)) // [R7]
        else $error("source copy code gives wrong result");
    rop_and_a : assert property ((rop.code == 4'h8) |-> (rop.res == (rop.src & rop.dst))) // [R7]
        else $error("and code gives wrong result");
endmodule : bce_rop_unit

//--- testbench/bce_mem_model.sv
// Display memory model that answers engine reads one cycle after the strobe.
`timescale 1ns/1ps
module bce_mem_model (
    input  wire logic        i_mclk,
    input  wire logic [17:0] i_mem_addr,
    input  wire logic        i_mem_rd,
    input  wire logic        i_mem_wr,
    input  wire logic [15:0] i_mem_wdata,
    output logic      [15:0] o_mem_rdata = 16'h0,
    output logic      [17:0] o_last_addr = 18'h0,
    output logic      [15:0] o_last_data = 16'h0
);
    // Data stands one cycle only, then inverts each cycle, so a sample one cycle late sees it inverted.
    always @(posedge i_mclk) begin
        o_mem_rdata <= i_mem_rd ? {i_mem_addr[7:0], 8'h3c} : ~o_mem_rdata;
        if (i_mem_wr) begin
            o_last_addr <= i_mem_addr;
            o_last_data <= i_mem_wdata;
        end
    end
endmodule : bce_mem_model

//--- testbench/tb_top.sv
// Self-checking bench for the blit command engine.
`timescale 1ns/1ps
module tb_top;
    logic i_mclk = 0, i_rst_b = 0, i_wr = 0, i_rd = 0, irq, m_rd, m_wr;
    logic [15:0] i_addr = 0, m_wd, m_rdat, l_data, e;
    logic [31:0] i_wdata = 0, o_rdata, d;
    logic [17:0] m_a, l_addr;
    int err_count = 0, checks_done = 0;
    // Source and destination pixels that the memory model and the FIFO supply.
    localparam logic [15:0] S_PIX = 16'h103c;
    localparam logic [15:0] D_PIX = 16'h203c;
    // Clock at 25 MHz.
    always #20 i_mclk = ~i_mclk;
    bce_engine uut (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_irq(irq), .o_mem_addr(m_a),
        .o_mem_rd(m_rd), .o_mem_wr(m_wr), .o_mem_wdata(m_wd), .i_mem_rdata(m_rdat));
    bce_mem_model mem (.i_mclk(i_mclk), .i_mem_addr(m_a), .i_mem_rd(m_rd), .i_mem_wr(m_wr),
        .i_mem_wdata(m_wd), .o_mem_rdata(m_rdat), .o_last_addr(l_addr), .o_last_data(l_data));
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : end_of_test
    task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
        checks_done++;
        if (g !== x) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", n, x, g);
        end
    endtask : chk
    task automatic wr(input logic [15:0] a, input logic [31:0] v);
        @(posedge i_mclk); i_addr <= a; i_wdata <= v; i_wr <= 1;
        @(posedge i_mclk); i_wr <= 0;
    endtask : wr
    task automatic rd(input logic [15:0] a);
        @(posedge i_mclk); i_addr <= a; i_rd <= 1;
        @(posedge i_mclk); i_rd <= 0;
        #1 d = o_rdata;
    endtask : rd
    task automatic wait_idle;
        for (int n = 0; n < 200; n++) begin
            rd(bce_pkg::REG_STATUS);
            if (d[0] === 1'b0) return;
        end
        chk("busy timeout", 0, 1);
        end_of_test;
    endtask : wait_idle
    task automatic t_reset;
        rd(bce_pkg::REG_COMMAND); chk("command", 0, d);
        rd(bce_pkg::REG_STATUS); chk("flags", 0, d & 32'h31);
        $display("reset test done");
    endtask : t_reset
    task automatic t_rop(input logic [3:0] op);
        wr(bce_pkg::REG_PATTERN, 32'h103c); wr(bce_pkg::REG_INT_MASK, 1);
        for (int r = 0; r < 16; r++) begin
            for (int i = 0; i < 16; i++) e[i] = r[{S_PIX[i], D_PIX[i]}];
            if (op == bce_pkg::OP_CEXP) e = S_PIX[r[2:0]] ? S_PIX : 16'h0;
            if (op == bce_pkg::OP_WRITE || op == bce_pkg::OP_CEXP)
                wr(bce_pkg::REG_DATA, {16'h0, S_PIX});
            wr(bce_pkg::REG_SRC, 32'h10); wr(bce_pkg::REG_DST, 32'h20);
            wr(bce_pkg::REG_COUNT, 1); wr(bce_pkg::REG_COMMAND, {12'h0, r[3:0], 12'h0, op});
            wr(bce_pkg::REG_CTRL, 1);
            rd(bce_pkg::REG_STATUS); chk("busy", 1, d[0]);
            wait_idle(); chk("irq", 1, irq); chk("waddr", 18'h20, l_addr);
            chk("result", e, l_data);
            wr(bce_pkg::REG_INT_STAT, 1); #1 chk("irq clear", 0, irq);
        end
        $display("rop test done for op %h", op);
    endtask : t_rop
    task automatic t_fifo;
        for (int i = 1; i <= 17; i++) begin
            wr(bce_pkg::REG_DATA, i);
            rd(bce_pkg::REG_STATUS);
            chk("half", i >= 8, d[5]);
            chk("full", i >= 16, d[4]);
        end
        rd(bce_pkg::REG_INT_STAT); chk("overflow", 1, d[1]);
        wr(bce_pkg::REG_INT_STAT, 2);
        for (int i = 1; i <= 16; i++) begin
            rd(bce_pkg::REG_DATA); chk("pop", i, d);
        end
        $display("fifo test done");
    endtask : t_fifo
    task automatic t_read;
        wr(bce_pkg::REG_SRC, 32'h40); wr(bce_pkg::REG_COUNT, 18);
        wr(bce_pkg::REG_COMMAND, 1); wr(bce_pkg::REG_CTRL, 1);
        repeat (100) @(posedge i_mclk);
        rd(bce_pkg::REG_STATUS); chk("used full", 16, d[28:24]);
        rd(bce_pkg::REG_DATA); chk("read data", 32'h403c, d);
        rd(bce_pkg::REG_DATA);
        repeat (20) @(posedge i_mclk);
        rd(bce_pkg::REG_STATUS); chk("used paused", 14, d[28:24]);
        rd(bce_pkg::REG_DATA); wait_idle();
        chk("used resumed", 15, d[28:24]);
        $display("read test done");
    endtask : t_read
    // Main sequence.
    initial begin
        repeat (10) @(posedge i_mclk);
        i_rst_b <= 1;
        t_reset(); t_rop(4'h2); t_rop(4'h3); t_rop(4'h6);
        t_rop(4'h0); t_rop(4'h8); t_fifo(); t_read();
        end_of_test();
    end
endmodule : tb_top
